// *** core/sdram_ca_pkg.sv ***
// shared constants and types of the dram command/address interface
`default_nettype none
package sdram_ca_pkg;
  localparam int BANK_COUNT   = 8;
  localparam int BANK_W       = 3;
  localparam int ROW_W        = 13;
  localparam int COL_W        = 10;
  localparam int WORD_W       = 16;
  localparam int PREFETCH     = 8;
  localparam int PAIR_W       = 2 * WORD_W;
  localparam int FETCH_W      = PREFETCH * WORD_W;
  localparam int FIFO_DEPTH   = 8;
  localparam int MODE_REGS    = 4;
  // address bits with extra duties
  localparam int PRECHARGE_FLAG_BIT = 10;
  localparam int CHOP_SELECT_BIT    = 12;
  // mode register 0 fields
  localparam int MR0_BL_LSB   = 0;
  localparam int MR0_TYPE_BIT = 3;
  localparam int MR0_CL_LSB   = 4;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_ON_FLY = 2'h1;
  // mode register 1 added latency field
  localparam int MR1_AL_LSB   = 3;
  localparam logic [1:0] AL_ZERO  = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;
  localparam logic [3:0] CL_BASE  = 4'h4;
  localparam logic [ROW_W-1:0] MODE_RESET = 13'h0000;
  // last pair index of a full and of a chopped burst
  localparam logic [1:0] LAST_FULL = 2'h3;
  localparam logic [1:0] LAST_CHOP = 2'h1;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE, CMD_ROW_OPEN, CMD_READ, CMD_WRITE
  } command_t;

  typedef enum logic [1:0] {BURST_IDLE, BURST_WAIT, BURST_RUN} burst_state_t;

  // command and address pins as sampled at the clock crossing
  typedef struct packed {
    logic              chip_select_n;
    logic              row_strobe_n;
    logic              column_strobe_n;
    logic              write_flag_n;
    logic [BANK_W-1:0] bank_select_lines;
    logic [ROW_W-1:0]  address;
  } ca_bus_t;

  // decoded command toward the array
  typedef struct packed {
    command_t          kind;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  address;
    logic              all_banks;
    logic              auto_precharge;
  } array_cmd_t;

  // one write pair toward the array
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic [PAIR_W-1:0] pair;
  } wr_entry_t;
endpackage
`default_nettype wire

// *** core/word_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0]      count, next_count;
  logic             push, pop;

  ////////////////////////////////////////////////////////////////
  // pointer and fill bookkeeping
  always_comb
  begin
    in_ready    = (count != (PW+1)'(DEPTH));
    out_valid   = (count != '0);
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage written at the write pointer
  always_ff @(posedge mclk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  assign out_data = store[rd_ptr];
endmodule // word_fifo
`default_nettype wire

// *** core/sdram_command_address_interface.sv ***
// command, address and data-path front end of an eight-bank x16 ddr dram
//
// Contract
// - capture inputs at true-rise, complement-fall crossing
// - read data one word per half-period; the code drives one word pair per clock on the rising edge
// - data qualified by strobe pair, not clock; the code samples write pairs on mclk rise while data_strobe_in is high
// - gate low freezes state from next cycle
// - power-down only with all banks idle
// - bank select lines choose one of eight
// - 13-bit row, 10-bit column from address
// - mode set loads address as opcode
// - flag bit high closes bank after burst
// - precharge flag high closes all banks
// - eight banks keep rows open concurrently
// - 16-bit words, eight banks
// - burst four or eight, sequential/interleaved order
// - added latency zero, latency-1, latency-2
// - eight-word prefetch streamed over half-periods; the code streams it as four word pairs, one per clock
// - chip select high masks all commands
// - row strobe only: row-open or precharge
// - column strobe only: read or write
// - chop select low shortens the burst
`default_nettype none
module sdram_command_address_interface (
  input  wire logic                             mclk,
  input  wire logic                             reset,
  input  wire logic                             clock_gate,
  input  wire sdram_ca_pkg::ca_bus_t            ca,
  input  wire logic [sdram_ca_pkg::PAIR_W-1:0]  dq_in,
  input  wire logic                             data_strobe_in,
  output logic      [sdram_ca_pkg::PAIR_W-1:0]  dq_out,
  output logic                                  dq_oe,
  output logic                                  data_strobe_out,
  output logic                                  complementary_strobe_out,
  output logic                                  data_strobe_oe,
  output logic                                  write_data_ready,
  output sdram_ca_pkg::array_cmd_t              array_cmd,
  output logic                                  array_cmd_valid,
  input  wire logic [sdram_ca_pkg::FETCH_W-1:0] array_rd_data,
  output logic                                  array_wr_valid,
  input  wire logic                             array_wr_ready,
  output sdram_ca_pkg::wr_entry_t               array_wr_entry,
  output logic      [sdram_ca_pkg::BANK_COUNT-1:0] bank_open_flags,
  output logic      [4:0]                       read_latency,
  output logic      [3:0]                       added_command_latency,
  output logic                                  burst_busy,
  output logic                                  power_down,
  output logic                                  self_refresh,
  output logic                                  refused
);
  import sdram_ca_pkg::*;

  ca_bus_t                ca_q;
  logic                   gate_q;
  command_t               raw_cmd, cmd;
  logic [ROW_W-1:0]       mode_reg [MODE_REGS];
  logic [ROW_W-1:0]       next_mode_reg [MODE_REGS];
  logic                   bank_open [BANK_COUNT];
  logic                   next_bank_open [BANK_COUNT];
  logic [ROW_W-1:0]       open_row [BANK_COUNT];
  logic [ROW_W-1:0]       next_open_row [BANK_COUNT];
  burst_state_t           burst_state, next_burst_state;
  logic [4:0]             wait_cnt, next_wait_cnt;
  logic [1:0]             beat, next_beat, last_beat, next_last_beat;
  logic                   burst_write, next_burst_write, burst_ap, next_burst_ap;
  logic                   interleave, next_interleave, fetch_pending, next_fetch_pending;
  logic [BANK_W-1:0]      burst_bank, next_burst_bank;
  logic [COL_W-1:0]       burst_col, next_burst_col;
  logic [FETCH_W-1:0]     prefetch, next_prefetch;
  logic [PAIR_W-1:0]      next_dq_out;
  logic                   next_dq_oe, next_self_refresh, next_refused, next_cmd_valid;
  array_cmd_t             next_cmd;
  logic [3:0]             cas_lat;
  logic                   frozen, access_ok, accepted, burst_close, full_burst, all_idle;
  logic                   push_valid, push_ready;
  wr_entry_t              push_entry;

  // position of the i-th word of a burst starting at a column
  function automatic logic [2:0] word_index(input logic [2:0] start, input logic [2:0] i,
                                            input logic inter);
    word_index = inter ? (start ^ i) : {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin capture on the rising crossing of the clock pair
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ca_q   <= '{chip_select_n: 1'b1, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                  write_flag_n: 1'b1, default: '0};
      gate_q <= 1'b1;
    end
    else
    begin
      ca_q   <= ca;
      gate_q <= clock_gate;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command decode, masked by chip select and the clock gate
  always_comb
  begin
    raw_cmd = CMD_NOP;
    if (!ca_q.chip_select_n)
    begin
      case ({ca_q.row_strobe_n, ca_q.column_strobe_n, ca_q.write_flag_n})
        3'h0:    raw_cmd = CMD_MODE_SET;
        3'h1:    raw_cmd = CMD_REFRESH;
        3'h2:    raw_cmd = CMD_PRECHARGE;
        3'h3:    raw_cmd = CMD_ROW_OPEN;
        3'h4:    raw_cmd = CMD_WRITE;
        3'h5:    raw_cmd = CMD_READ;
        default: raw_cmd = CMD_NOP;
      endcase
    end
    frozen = !gate_q;
    cmd    = frozen ? CMD_NOP : raw_cmd;
  end

  // latency and burst length from the mode registers
  always_comb
  begin
    cas_lat = 4'(mode_reg[0][MR0_CL_LSB +: 3]) + CL_BASE;
    case (mode_reg[1][MR1_AL_LSB +: 2])
      AL_CL_M1: added_command_latency = cas_lat - 4'h1;
      AL_CL_M2: added_command_latency = cas_lat - 4'h2;
      default:  added_command_latency = 4'h0;
    endcase
    read_latency = 5'(cas_lat) + 5'(added_command_latency);
    full_burst   = (mode_reg[0][MR0_BL_LSB +: 2] == BL_FIXED8) ||
                   ((mode_reg[0][MR0_BL_LSB +: 2] == BL_ON_FLY) && ca_q.address[CHOP_SELECT_BIT]);
    access_ok    = bank_open[ca_q.bank_select_lines] && (burst_state == BURST_IDLE);
    accepted     = ((cmd != CMD_READ) && (cmd != CMD_WRITE)) || access_ok;
    burst_close  = !frozen && (burst_state == BURST_RUN) && burst_ap && (beat == last_beat) &&
                   (!burst_write || (data_strobe_in && push_ready)); // close only once the last pair is taken
  end

  ////////////////////////////////////////////////////////////////
  // mode registers loaded with the address opcode
  always_comb
  begin
    for (int m = 0; m < MODE_REGS; m++)
      next_mode_reg[m] = mode_reg[m];
    if (cmd == CMD_MODE_SET && !ca_q.bank_select_lines[2])
      next_mode_reg[ca_q.bank_select_lines[1:0]] = ca_q.address;
  end

  // per-bank open flag and open row
  for (genvar g = 0; g < BANK_COUNT; g++)
  begin : bank_slot
    always_comb
    begin
      next_bank_open[g] = bank_open[g];
      next_open_row[g]  = open_row[g];
      if (cmd == CMD_ROW_OPEN && ca_q.bank_select_lines == BANK_W'(g))
      begin
        next_bank_open[g] = 1'b1;
        next_open_row[g]  = ca_q.address;
      end
      if (cmd == CMD_PRECHARGE && (ca_q.address[PRECHARGE_FLAG_BIT] ||
          ca_q.bank_select_lines == BANK_W'(g)))
        next_bank_open[g] = 1'b0;
      if (burst_close && burst_bank == BANK_W'(g))
        next_bank_open[g] = 1'b0;
    end
    assign bank_open_flags[g] = bank_open[g];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int m = 0; m < MODE_REGS; m++)
        mode_reg[m] <= MODE_RESET;
      for (int b = 0; b < BANK_COUNT; b++)
      begin
        bank_open[b] <= 1'b0;
        open_row[b]  <= '0;
      end
    end
    else
    begin
      mode_reg  <= next_mode_reg;
      bank_open <= next_bank_open;
      open_row  <= next_open_row;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command forwarding, refusal and low-power status
  always_comb
  begin
    all_idle          = (bank_open_flags == '0);
    next_cmd_valid    = (cmd != CMD_NOP) && accepted;
    next_refused      = (cmd != CMD_NOP) && !accepted;
    next_cmd.kind     = cmd;
    next_cmd.bank     = ca_q.bank_select_lines;
    next_cmd.address  = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) ?
                        ROW_W'(ca_q.address[COL_W-1:0]) : ca_q.address;
    next_cmd.all_banks      = (cmd == CMD_PRECHARGE) && ca_q.address[PRECHARGE_FLAG_BIT];
    next_cmd.auto_precharge = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) &&
                              ca_q.address[PRECHARGE_FLAG_BIT];
    next_self_refresh = self_refresh;
    if (gate_q)
      next_self_refresh = 1'b0;
    else if (raw_cmd == CMD_REFRESH && all_idle)
      next_self_refresh = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      array_cmd       <= '{kind: CMD_NOP, default: '0};
      array_cmd_valid <= 1'b0;
      refused         <= 1'b0;
      self_refresh    <= 1'b0;
    end
    else
    begin
      array_cmd       <= next_cmd;
      array_cmd_valid <= next_cmd_valid;
      refused         <= next_refused;
      self_refresh    <= next_self_refresh;
    end
  end

  assign power_down = frozen && all_idle && !self_refresh;

  ////////////////////////////////////////////////////////////////
  // burst engine: latency wait, then one word pair per clock
  always_comb
  begin
    next_burst_state   = burst_state;
    next_wait_cnt      = wait_cnt;
    next_beat          = beat;
    next_last_beat     = last_beat;
    next_burst_write   = burst_write;
    next_burst_ap      = burst_ap;
    next_interleave    = interleave;
    next_burst_bank    = burst_bank;
    next_burst_col     = burst_col;
    next_fetch_pending = fetch_pending;
    next_prefetch      = prefetch;
    next_dq_out        = dq_out;
    next_dq_oe         = dq_oe;
    push_valid         = 1'b0;
    if (!frozen)
    begin
      next_dq_oe = 1'b0;
      if (fetch_pending)
      begin
        next_prefetch      = array_rd_data;
        next_fetch_pending = 1'b0;
      end
      case (burst_state)
        BURST_IDLE:
          if (next_cmd_valid && (cmd == CMD_READ || cmd == CMD_WRITE))
          begin
            next_burst_state   = BURST_WAIT;
            next_burst_write   = (cmd == CMD_WRITE);
            next_wait_cnt      = (cmd == CMD_WRITE) ? read_latency - 5'h2 : read_latency - 5'h1;
            next_beat          = 2'h0;
            next_last_beat     = full_burst ? LAST_FULL : LAST_CHOP;
            next_burst_ap      = ca_q.address[PRECHARGE_FLAG_BIT];
            next_interleave    = mode_reg[0][MR0_TYPE_BIT];
            next_burst_bank    = ca_q.bank_select_lines;
            next_burst_col     = ca_q.address[COL_W-1:0];
            next_fetch_pending = (cmd == CMD_READ);
          end
        BURST_WAIT:
          if (wait_cnt == 5'h0)
            next_burst_state = BURST_RUN;
          else
            next_wait_cnt = wait_cnt - 5'h1;
        BURST_RUN:
          if (burst_write)
          begin
            push_valid = data_strobe_in;
            if (data_strobe_in && push_ready)
            begin
              next_beat = beat + 2'h1;
              if (beat == last_beat)
                next_burst_state = BURST_IDLE;
            end
          end
          else
          begin
            next_dq_oe  = 1'b1;
            next_dq_out = {prefetch[WORD_W*word_index(burst_col[2:0], {beat, 1'b1}, interleave) +: WORD_W],
                           prefetch[WORD_W*word_index(burst_col[2:0], {beat, 1'b0}, interleave) +: WORD_W]};
            next_beat   = beat + 2'h1;
            if (beat == last_beat)
              next_burst_state = BURST_IDLE;
          end
        default: next_burst_state = BURST_IDLE;
      endcase
    end
    push_entry.bank = burst_bank;
    push_entry.col  = {burst_col[COL_W-1:3], beat, 1'b0};
    push_entry.pair = dq_in;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      burst_state   <= BURST_IDLE;
      wait_cnt      <= '0;
      beat          <= '0;
      last_beat     <= '0;
      burst_write   <= 1'b0;
      burst_ap      <= 1'b0;
      interleave    <= 1'b0;
      burst_bank    <= '0;
      burst_col     <= '0;
      fetch_pending <= 1'b0;
      prefetch      <= '0;
      dq_out        <= '0;
      dq_oe         <= 1'b0;
    end
    else
    begin
      burst_state   <= next_burst_state;
      wait_cnt      <= next_wait_cnt;
      beat          <= next_beat;
      last_beat     <= next_last_beat;
      burst_write   <= next_burst_write;
      burst_ap      <= next_burst_ap;
      interleave    <= next_interleave;
      burst_bank    <= next_burst_bank;
      burst_col     <= next_burst_col;
      fetch_pending <= next_fetch_pending;
      prefetch      <= next_prefetch;
      dq_out        <= next_dq_out;
      dq_oe         <= next_dq_oe;
    end
  end

  // strobe pair travels with the read data
  assign data_strobe_out          = dq_oe;
  assign complementary_strobe_out = !dq_oe;
  assign data_strobe_oe           = dq_oe;
  assign burst_busy               = (burst_state != BURST_IDLE);
  assign write_data_ready         = push_ready && (burst_state == BURST_RUN) && burst_write;

  // write pairs buffered toward the array
  word_fifo #(.WIDTH($bits(wr_entry_t)), .DEPTH(FIFO_DEPTH)) write_buffer (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_entry),
    .out_valid (array_wr_valid),
    .out_ready (array_wr_ready),
    .out_data  (array_wr_entry)
  );

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  chip_select_mask_a: assert property (ca_q.chip_select_n |=> !array_cmd_valid && !refused)
    else $error("command taken with chip select high");
  row_open_a: assert property (cmd == CMD_ROW_OPEN |=> bank_open_flags[$past(ca_q.bank_select_lines)]
    && open_row[$past(ca_q.bank_select_lines)] == $past(ca_q.address))
    else $error("row open did not open the selected bank");
  precharge_all_a: assert property (cmd == CMD_PRECHARGE && ca_q.address[PRECHARGE_FLAG_BIT]
    |=> bank_open_flags == '0)
    else $error("precharge all left a bank open");
  precharge_one_a: assert property (cmd == CMD_PRECHARGE && !ca_q.address[PRECHARGE_FLAG_BIT]
    |=> !bank_open_flags[$past(ca_q.bank_select_lines)])
    else $error("single precharge missed its bank");
  freeze_hold_a: assert property (frozen |=> $stable(dq_out) && $stable(dq_oe) && $stable(beat))
    else $error("state moved while the clock gate was low");
  power_down_a: assert property (power_down |-> bank_open_flags == '0 && !gate_q)
    else $error("power down with an open bank");
  full_burst_a: assert property ($rose(dq_oe) && last_beat == LAST_FULL |-> dq_oe [*4])
    else $error("full read burst shorter than four pairs");
  strobe_pair_a: assert property (data_strobe_oe == dq_oe && complementary_strobe_out != data_strobe_out)
    else $error("strobe pair out of step with data");
  auto_close_a: assert property (burst_close |=> !bank_open_flags[$past(burst_bank)])
    else $error("auto precharge did not close the bank");
  mode_load_a: assert property (cmd == CMD_MODE_SET && !ca_q.bank_select_lines[2]
    |=> mode_reg[$past(ca_q.bank_select_lines[1:0])] == $past(ca_q.address))
    else $error("mode register not loaded with opcode");

  read_burst_c: cover property (burst_state == BURST_RUN && !burst_write ##1 dq_oe);
  write_push_c: cover property (push_valid && push_ready);
  precharge_all_c: cover property (cmd == CMD_PRECHARGE && ca_q.address[PRECHARGE_FLAG_BIT]);
  power_down_c: cover property (power_down);
endmodule // sdram_command_address_interface
`default_nettype wire

// *** test/ctrl_model.sv ***
// controller model: command pins and write data toward the device
`default_nettype none
module ctrl_model (
  input  wire logic                       mclk,
  input  wire logic                       write_data_ready,
  output sdram_ca_pkg::ca_bus_t           ca,
  output logic                            clock_gate,
  output logic [sdram_ca_pkg::PAIR_W-1:0] dq_in,
  output logic                            data_strobe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_ca_pkg::*;
  localparam int REFRESH_GAP = 390;
  // pins idle: deselected, no data
  initial
  begin
    ca = '1;
    clock_gate = 1'b1;
    dq_in = '0;
    data_strobe_in = 1'b0;
  end
  ////////////////////////////////////////
  // one command held across one edge, then released with inverted lines
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] b, input logic [12:0] a, input logic sel_n = 1'b0);
    @(posedge mclk);
    #2;
    ca = {sel_n, rcw, b, a};
    @(posedge mclk);
    #2;
    ca = {1'b1, ~rcw, ~b, ~a};
  endtask
  // write pairs, each held until the device takes it
  task automatic send(input int n, input logic [31:0] base);
    data_strobe_in = 1'b1;
    for (int p = 0; p < n; p++)
    begin
      dq_in = base + 32'(p);
      for (int k = 0; k < 40 && write_data_ready !== 1'b1; k++)
        @(negedge mclk);
      if (write_data_ready !== 1'b1)
      begin
        testbench.mismatches++;
        testbench.tally_and_finish;
      end
      @(posedge mclk);
      #2;
    end
    data_strobe_in = 1'b0;
    dq_in = ~dq_in;
  endtask
  // refreshes at the normal-temperature interval
  task automatic refresh(input int n);
    repeat (n)
    begin
      cmd(3'b001, 3'h0, 13'h0000);
      repeat (REFRESH_GAP - 2) @(posedge mclk);
    end
  endtask
  // close every bank before stopping the clock gate
  task automatic sleep;
    cmd(3'b010, 3'h0, 13'h0400);
    clock_gate = 1'b0;
  endtask
endmodule // ctrl_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the dram command/address front end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_ca_pkg::*;
  logic         mclk, reset, clock_gate, data_strobe_in, dq_oe, data_strobe_out, data_strobe_oe;
  logic         complementary_strobe_out, write_data_ready, array_cmd_valid, array_wr_valid;
  logic         array_wr_ready, burst_busy, power_down, self_refresh, refused;
  logic [31:0]  dq_in, dq_out;
  logic [127:0] array_rd_data;
  logic [7:0]   bank_open_flags;
  logic [4:0]   read_latency;
  logic [3:0]   added_command_latency;
  ca_bus_t      ca;
  array_cmd_t   array_cmd;
  wr_entry_t    array_wr_entry;
  wr_entry_t    got[$];
  int           mismatches, check_count;
  sdram_command_address_interface uut (.mclk, .reset, .clock_gate, .ca, .dq_in, .data_strobe_in, .dq_out, .dq_oe,
    .data_strobe_out, .complementary_strobe_out, .data_strobe_oe, .write_data_ready, .array_cmd, .array_cmd_valid,
    .array_rd_data, .array_wr_valid, .array_wr_ready, .array_wr_entry, .bank_open_flags, .read_latency,
    .added_command_latency, .burst_busy, .power_down, .self_refresh, .refused);
  ctrl_model ctrl (.mclk, .write_data_ready, .ca, .clock_gate, .dq_in, .data_strobe_in);
  // clock and array-side write collector
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (array_wr_valid && array_wr_ready)
      got.push_back(array_wr_entry);
  ////////////////////////////////////////
  // compare, report and finish
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////
  // latency 5, burst by chop line, then each added latency code
  task automatic t_mode;
    ctrl.cmd(3'b000, 3'h0, 13'h0011);
    step;
    check("rd_lat", read_latency, 5'h05);
    for (int m = 0; m < 3; m++)
    begin
      ctrl.cmd(3'b000, 3'h1, 13'(m << 3));
      step;
      check("add_lat", added_command_latency, (m == 0) ? 4'h0 : 4'(5 - m));
    end
    ctrl.cmd(3'b000, 3'h1, 13'h0000);
  endtask
  // deselected command ignored, then a row opened in every bank
  task automatic t_open;
    ctrl.cmd(3'b011, 3'h5, 13'h1ABC, 1'b1);
    step;
    check("masked", {array_cmd_valid, bank_open_flags}, 9'h000);
    for (int b = 0; b < 8; b++)
    begin
      ctrl.cmd(3'b011, 3'(b), 13'h1AB0 + 13'(b));
      step;
      check("open", {array_cmd_valid, array_cmd.kind, array_cmd.bank, array_cmd.address},
            {1'b1, CMD_ROW_OPEN, 3'(b), 13'h1AB0 + 13'(b)});
    end
    check("flags", bank_open_flags, 8'hFF);
  endtask
  // read burst of n pairs from a constant array pattern; x is the interleave mask of the start column
  task automatic t_read(input logic [2:0] b, input logic [12:0] a, input int n, input int x = 0);
    ctrl.cmd(3'b101, b, a);
    step;
    check("rd_cmd", {array_cmd_valid, burst_busy, array_cmd.kind, array_cmd.bank, array_cmd.auto_precharge,
          array_cmd.address}, {2'b11, CMD_READ, b, a[10], 3'h0, a[9:0]});
    repeat (5) step;
    for (int p = 0; p < n; p++)
    begin
      step;
      check("rd_pair", {dq_oe, data_strobe_out, data_strobe_oe, complementary_strobe_out, dq_out},
            {4'b1110, 16'hA000 + 16'((2 * p + 1) ^ x), 16'hA000 + 16'((2 * p) ^ x)});
    end
    step;
    check("rd_end", dq_oe, 1'b0);
  endtask
  // write burst into a stalled array, then drained
  task automatic t_write;
    ctrl.cmd(3'b100, 3'h2, 13'h1008);
    ctrl.send(4, 32'hC0DE0000);
    repeat (4) step;
    check("stall", {array_wr_valid, 8'(got.size())}, 9'h100);
    #1;
    array_wr_ready = 1'b1;
    repeat (6) step;
    check("wr_cnt", got.size(), 48'h4);
    for (int p = 0; p < 4; p++)
      check("wr", got[p], {3'h2, 10'h008 + 10'(2 * p), 32'hC0DE0000 + 32'(p)});
  endtask
  ////////////////////////////////////////
  // hang guard
  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    array_wr_ready = 1'b0;
    for (int w = 0; w < 8; w++)
      array_rd_data[16 * w +: 16] = 16'hA000 + 16'(w);
    repeat (20) @(posedge mclk);
    #2;
    reset = 1'b0;
    check("rst", {complementary_strobe_out, read_latency, added_command_latency}, 10'h240);
    ctrl.refresh(1);
    t_mode;
    t_open;
    t_read(3'h5, 13'h1000, 4);
    t_read(3'h6, 13'h0400, 2);
    check("auto_pre", bank_open_flags, 8'hBF);
    ctrl.cmd(3'b101, 3'h6, 13'h1000);
    step;
    check("refuse", {refused, array_cmd_valid}, 2'b10);
    ctrl.cmd(3'b010, 3'h3, 13'h0000);
    step;
    check("pre_one", bank_open_flags, 8'hB7);
    ctrl.cmd(3'b000, 3'h0, 13'h0018);
    t_read(3'h5, 13'h0003, 4, 3);
    t_write;
    ctrl.sleep;
    step;
    check("pre_all", {array_cmd_valid, array_cmd.all_banks, bank_open_flags}, 10'h300);
    repeat (2) step;
    check("pdown", power_down, 1'b1);
    ctrl.cmd(3'b011, 3'h0, 13'h0000);
    step;
    check("gated", {array_cmd_valid, bank_open_flags}, 9'h000);
    ctrl.cmd(3'b001, 3'h0, 13'h0000);
    step;
    check("self_ref", {self_refresh, power_down, array_cmd_valid}, 3'b100);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
